/* common/uefr_pkg.sv */
/*
 * Package for the enhanced flow register group: offsets, field positions,
 * reset values and the flow-control state encoding.
 * Assumes an 8-bit register port with 8-bit offsets.
 */
`default_nettype none
package uefr_pkg;
    // ********************************
    // register offsets
    // ********************************
    localparam logic [7:0] UEFR_OFF_SPECIAL_FN = 8'h07;
    localparam logic [7:0] UEFR_OFF_FEATURE = 8'h08;
    localparam logic [7:0] UEFR_OFF_RESUME_ONE = 8'h0b;
    localparam logic [7:0] UEFR_OFF_RESUME_TWO = 8'h0c;
    localparam logic [7:0] UEFR_OFF_PAUSE_ONE = 8'h0d;
    localparam logic [7:0] UEFR_OFF_PAUSE_TWO = 8'h0e;
    localparam logic [7:0] UEFR_OFF_ADV_STATUS = 8'h0f;
    localparam logic [7:0] UEFR_OFF_TX_IRQ_LEVEL = 8'h10;
    localparam logic [7:0] UEFR_OFF_RX_IRQ_LEVEL = 8'h11;
    localparam logic [7:0] UEFR_OFF_FLOW_LOW = 8'h12;
    localparam logic [7:0] UEFR_OFF_FLOW_HIGH = 8'h13;
    localparam logic [7:0] UEFR_OFF_PRESCALE = 8'h14;
    localparam logic [7:0] UEFR_OFF_RX_COUNT = 8'h15;
    localparam logic [7:0] UEFR_OFF_TX_COUNT = 8'h16;

    // ********************************
    // field positions
    // ********************************
    localparam int UEFR_ADV_TERMINATE = 0;
    localparam int UEFR_ADV_REMOTE_DIS = 1;
    localparam int UEFR_ADV_FLOW_DET = 2;
    localparam int UEFR_ADV_SPECIAL_DET = 3;
    localparam int UEFR_SFN_RX_SEL = 6;
    localparam int UEFR_SFN_TX_SEL = 7;
    localparam int UEFR_FEAT_RXMODE_LO = 0;
    localparam int UEFR_FEAT_ENHANCED = 4;
    localparam int UEFR_FEAT_SPECIAL_EN = 5;
    localparam int UEFR_FEAT_AUTO_RTS = 6;
    localparam int UEFR_PRESCALE_N_LO = 0;
    localparam int UEFR_PRESCALE_M_LO = 4;

    // ********************************
    // reset values and encodings
    // ********************************
    localparam logic [7:0] UEFR_RESET_BYTE = 8'h00;
    localparam logic [1:0] UEFR_RXMODE_PAIR_TWO = 2'h1;
    localparam logic [1:0] UEFR_RXMODE_PAIR_ONE = 2'h2;
    localparam logic [1:0] UEFR_RXMODE_EITHER = 2'h3;

    typedef enum logic [0:0] {
        UEFR_RTS_RUN = 1'b0,
        UEFR_RTS_HALT = 1'b1
    } uefr_rts_type;
endpackage
`default_nettype wire

/* rtl/uefr_char_match.sv */
/*
 * Compares one received character with the programmed resume/pause pairs
 * under the receive in-band mode field.
 * Assumes character and strobe come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module uefr_char_match
    import uefr_pkg::*;
(
    input wire logic [7:0] char_i,
    input wire logic [1:0] mode_i,
    input wire logic [7:0] resume_one_i,
    input wire logic [7:0] resume_two_i,
    input wire logic [7:0] pause_one_i,
    input wire logic [7:0] pause_two_i,
    output logic resume_hit_o,
    output logic pause_hit_o,
    output logic special_hit_o
);
    logic use_one;
    logic use_two;

    always_comb begin
        use_one = (mode_i == UEFR_RXMODE_PAIR_ONE) || (mode_i == UEFR_RXMODE_EITHER);
        use_two = (mode_i == UEFR_RXMODE_PAIR_TWO) || (mode_i == UEFR_RXMODE_EITHER);
        resume_hit_o = (use_one && char_i == resume_one_i) ||
                       (use_two && char_i == resume_two_i);
        pause_hit_o = (use_one && char_i == pause_one_i) ||
                      (use_two && char_i == pause_two_i);
        // special detection looks at both pause characters whatever the mode
        special_hit_o = (char_i == pause_one_i) || (char_i == pause_two_i);
    end
endmodule
`default_nettype wire

/* rtl/uefr_regs.sv */
/*
 * Enhanced flow register group of one UART channel: flow characters,
 * advanced status, trigger levels, prescaler, FIFO occupancy windows,
 * receive in-band flow recognition and automatic request-to-send.
 * Assumes the FIFO counts and received-character strobe come from logic on
 * CLK_SYS_I; the remote terminate/remote disable levels arrive from the
 * transmitter on the same clock. Register port: one-cycle strobes, read
 * data one cycle after the read strobe.
 */
// Our own choice: the strobed register port.
// Summary of operation
// - two resume and two pause characters, read/write, zero at reset
// - status bit 0 reads 1 while transmitter halted by remote terminate
// - status bit 1 shows remote transmit disabled after pause or rts sent
// - status bit 2 set on resume/pause received, cleared by reading
// - status bit 3 set on special character received, cleared by reading
// - bits 2 and 3 raise the level-6 interrupt source when enabled
// - transmit interrupt trigger level register, read/write, zero at reset
// - receive interrupt trigger level register, read/write, zero at reset
// - low threshold register releases remote below its level
// - high threshold register halts remote at its level
// - prescale register holds N in bits 3:0 and M in bits 7:4
// - special-function bit 6 selects receive or line-status count at 15h
// - receive FIFO count is read-only, zero at reset
// - line-status FIFO count is read-only, zero at reset
// - special-function bit 7 makes 16h the transmit FIFO count
// - transmit FIFO count is read-only, zero at reset
// - auto rts goes inactive at high threshold, returns below low
// - receive mode 01 uses second pair, 10 first pair
`timescale 1ns/1ps
`default_nettype none
module uefr_regs
    import uefr_pkg::*;
#(
    parameter int COUNT_W = 8
)
(
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic [COUNT_W-1:0] RX_COUNT_I,
    input wire logic [COUNT_W-1:0] LINE_STAT_COUNT_I,
    input wire logic [COUNT_W-1:0] TX_COUNT_I,
    input wire logic [7:0] SAMPLE_CLK_I,
    input wire logic [7:0] RX_CHAR_I,
    input wire logic RX_CHAR_VALID_I,
    input wire logic REMOTE_TERM_I,
    input wire logic REMOTE_DIS_I,
    input wire logic PAUSE_IRQ_EN_I,
    output logic TX_HALT_O,
    output logic RTS_N_O,
    output logic FLOW_IRQ_O,
    output logic [7:0] TX_IRQ_LEVEL_O,
    output logic [7:0] RX_IRQ_LEVEL_O,
    output logic [3:0] PRESCALE_N_O,
    output logic [3:0] PRESCALE_M_O
);
    // ********************************
    // storage
    // ********************************
    logic [7:0] special_function_reg;
    logic [7:0] enhanced_feature_reg;
    logic [7:0] resume_char_one;
    logic [7:0] resume_char_two;
    logic [7:0] pause_char_one;
    logic [7:0] pause_char_two;
    logic [7:0] tx_irq_level;
    logic [7:0] rx_irq_level;
    logic [7:0] flow_low_threshold;
    logic [7:0] flow_high_threshold;
    logic [7:0] baud_prescale;
    logic flow_detect;
    logic special_detect;
    logic remote_term_q;
    logic remote_dis_q;
    uefr_rts_type rts_state;
    uefr_rts_type next_rts_state;
    logic [7:0] next_rdata;
    logic resume_hit;
    logic pause_hit;
    logic special_hit;
    logic enhanced;
    logic rd_status;
    logic [7:0] rx_level8;

    assign enhanced = enhanced_feature_reg[UEFR_FEAT_ENHANCED];
    assign rd_status = RD_I && (ADDR_I == UEFR_OFF_ADV_STATUS);
    assign rx_level8 = 8'(RX_COUNT_I);

    uefr_char_match u_match (
        .char_i(RX_CHAR_I),
        .mode_i(enhanced_feature_reg[UEFR_FEAT_RXMODE_LO +: 2]),
        .resume_one_i(resume_char_one),
        .resume_two_i(resume_char_two),
        .pause_one_i(pause_char_one),
        .pause_two_i(pause_char_two),
        .resume_hit_o(resume_hit),
        .pause_hit_o(pause_hit),
        .special_hit_o(special_hit)
    );

    // ********************************
    // software-written registers
    // ********************************
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            special_function_reg <= UEFR_RESET_BYTE;
            enhanced_feature_reg <= UEFR_RESET_BYTE;
            resume_char_one <= UEFR_RESET_BYTE;
            resume_char_two <= UEFR_RESET_BYTE;
            pause_char_one <= UEFR_RESET_BYTE;
            pause_char_two <= UEFR_RESET_BYTE;
            tx_irq_level <= UEFR_RESET_BYTE;
            rx_irq_level <= UEFR_RESET_BYTE;
            flow_low_threshold <= UEFR_RESET_BYTE;
            flow_high_threshold <= UEFR_RESET_BYTE;
            baud_prescale <= UEFR_RESET_BYTE;
        end else if (WR_I) begin
            // read-only offsets fall through untouched
            if (ADDR_I == UEFR_OFF_SPECIAL_FN) begin
                special_function_reg <= WDATA_I;
            end else if (ADDR_I == UEFR_OFF_FEATURE) begin
                enhanced_feature_reg <= WDATA_I;
            end else if (ADDR_I == UEFR_OFF_RESUME_ONE) begin
                resume_char_one <= WDATA_I;
            end else if (ADDR_I == UEFR_OFF_RESUME_TWO) begin
                resume_char_two <= WDATA_I;
            end else if (ADDR_I == UEFR_OFF_PAUSE_ONE) begin
                pause_char_one <= WDATA_I;
            end else if (ADDR_I == UEFR_OFF_PAUSE_TWO) begin
                pause_char_two <= WDATA_I;
            end else if (ADDR_I == UEFR_OFF_TX_IRQ_LEVEL) begin
                tx_irq_level <= WDATA_I;
            end else if (ADDR_I == UEFR_OFF_RX_IRQ_LEVEL) begin
                rx_irq_level <= WDATA_I;
            end else if (ADDR_I == UEFR_OFF_FLOW_LOW) begin
                flow_low_threshold <= WDATA_I;
            end else if (ADDR_I == UEFR_OFF_FLOW_HIGH) begin
                flow_high_threshold <= WDATA_I;
            end else if (ADDR_I == UEFR_OFF_PRESCALE) begin
                // M values above 2 are stored as written
                baud_prescale <= WDATA_I;
            end
        end
    end

    // ********************************
    // sticky detect flags
    // ********************************
    // a detection in the very read cycle survives: set wins over clear
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            flow_detect <= 1'b0;
        end else if (RX_CHAR_VALID_I && (resume_hit || pause_hit)) begin
            flow_detect <= 1'b1;
        end else if (rd_status) begin
            flow_detect <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            special_detect <= 1'b0;
        end else if (RX_CHAR_VALID_I && special_hit && enhanced &&
                     enhanced_feature_reg[UEFR_FEAT_SPECIAL_EN]) begin
            special_detect <= 1'b1;
        end else if (rd_status) begin
            special_detect <= 1'b0;
        end
    end

    // ********************************
    // transmitter state mirrors
    // ********************************
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            remote_term_q <= 1'b0;
            remote_dis_q <= 1'b0;
        end else begin
            remote_term_q <= REMOTE_TERM_I;
            remote_dis_q <= REMOTE_DIS_I;
        end
    end

    // in-band halt: pause stops the transmitter until a resume arrives or the receive mode field is 00
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            TX_HALT_O <= 1'b0;
        end else if (RX_CHAR_VALID_I && pause_hit) begin
            TX_HALT_O <= 1'b1;
        end else if (RX_CHAR_VALID_I && resume_hit) begin
            TX_HALT_O <= 1'b0;
        end else if (enhanced_feature_reg[UEFR_FEAT_RXMODE_LO +: 2] == 2'h0) begin
            TX_HALT_O <= 1'b0;
        end
    end

    // ********************************
    // automatic request-to-send
    // ********************************
    // hysteresis between the two thresholds keeps rts from chattering
    always_comb begin
        next_rts_state = rts_state;
        case (rts_state)
            UEFR_RTS_RUN: begin
                if (rx_level8 >= flow_high_threshold) begin
                    next_rts_state = UEFR_RTS_HALT;
                end
            end
            UEFR_RTS_HALT: begin
                if (rx_level8 < flow_low_threshold) begin
                    next_rts_state = UEFR_RTS_RUN;
                end
            end
            default: begin
                next_rts_state = UEFR_RTS_RUN;
            end
        endcase
        if (!(enhanced && enhanced_feature_reg[UEFR_FEAT_AUTO_RTS])) begin
            next_rts_state = UEFR_RTS_RUN;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rts_state <= UEFR_RTS_RUN;
            RTS_N_O <= 1'b0;
        end else begin
            rts_state <= next_rts_state;
            RTS_N_O <= (next_rts_state == UEFR_RTS_HALT);
        end
    end

    // ********************************
    // interrupt source and config outputs
    // ********************************
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            FLOW_IRQ_O <= 1'b0;
            TX_IRQ_LEVEL_O <= UEFR_RESET_BYTE;
            RX_IRQ_LEVEL_O <= UEFR_RESET_BYTE;
            PRESCALE_N_O <= 4'h0;
            PRESCALE_M_O <= 4'h0;
        end else begin
            FLOW_IRQ_O <= PAUSE_IRQ_EN_I && (flow_detect || special_detect);
            TX_IRQ_LEVEL_O <= tx_irq_level;
            RX_IRQ_LEVEL_O <= rx_irq_level;
            PRESCALE_N_O <= baud_prescale[UEFR_PRESCALE_N_LO +: 4];
            PRESCALE_M_O <= baud_prescale[UEFR_PRESCALE_M_LO +: 4];
        end
    end

    // ********************************
    // read path
    // ********************************
    always_comb begin
        next_rdata = UEFR_RESET_BYTE;
        if (ADDR_I == UEFR_OFF_SPECIAL_FN) begin
            next_rdata = special_function_reg;
        end else if (ADDR_I == UEFR_OFF_FEATURE) begin
            next_rdata = enhanced_feature_reg;
        end else if (ADDR_I == UEFR_OFF_RESUME_ONE) begin
            next_rdata = resume_char_one;
        end else if (ADDR_I == UEFR_OFF_RESUME_TWO) begin
            next_rdata = resume_char_two;
        end else if (ADDR_I == UEFR_OFF_PAUSE_ONE) begin
            next_rdata = pause_char_one;
        end else if (ADDR_I == UEFR_OFF_PAUSE_TWO) begin
            next_rdata = pause_char_two;
        end else if (ADDR_I == UEFR_OFF_ADV_STATUS) begin
            // upper nibble stays zero
            next_rdata[UEFR_ADV_TERMINATE] = remote_term_q;
            next_rdata[UEFR_ADV_REMOTE_DIS] = remote_dis_q;
            next_rdata[UEFR_ADV_FLOW_DET] = flow_detect;
            next_rdata[UEFR_ADV_SPECIAL_DET] = special_detect;
        end else if (ADDR_I == UEFR_OFF_TX_IRQ_LEVEL) begin
            next_rdata = tx_irq_level;
        end else if (ADDR_I == UEFR_OFF_RX_IRQ_LEVEL) begin
            next_rdata = rx_irq_level;
        end else if (ADDR_I == UEFR_OFF_FLOW_LOW) begin
            next_rdata = flow_low_threshold;
        end else if (ADDR_I == UEFR_OFF_FLOW_HIGH) begin
            next_rdata = flow_high_threshold;
        end else if (ADDR_I == UEFR_OFF_PRESCALE) begin
            next_rdata = baud_prescale;
        end else if (ADDR_I == UEFR_OFF_RX_COUNT) begin
            if (special_function_reg[UEFR_SFN_RX_SEL]) begin
                next_rdata = 8'(RX_COUNT_I);
            end else begin
                next_rdata = 8'(LINE_STAT_COUNT_I);
            end
        end else if (ADDR_I == UEFR_OFF_TX_COUNT) begin
            if (special_function_reg[UEFR_SFN_TX_SEL]) begin
                next_rdata = 8'(TX_COUNT_I);
            end else begin
                next_rdata = SAMPLE_CLK_I;
            end
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RDATA_O <= UEFR_RESET_BYTE;
        end else if (RD_I) begin
            RDATA_O <= next_rdata;
        end else begin
            RDATA_O <= UEFR_RESET_BYTE;
        end
    end
endmodule
`default_nettype wire

/* dv/uefr_regs_sva.sv */
/* Checker for the enhanced flow register group, bound to uefr_regs.
   Assumes only the top module's ports; shadows feature and threshold
   registers from the write strobe. */
`timescale 1ns/1ps
`default_nettype none
module uefr_regs_sva
    import uefr_pkg::*;
#(
    parameter int COUNT_W = 8
)
(
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic [COUNT_W-1:0] RX_COUNT_I,
    input wire logic REMOTE_TERM_I,
    input wire logic REMOTE_DIS_I,
    input wire logic PAUSE_IRQ_EN_I,
    input wire logic RTS_N_O,
    input wire logic FLOW_IRQ_O,
    input wire logic [7:0] TX_IRQ_LEVEL_O,
    input wire logic [3:0] PRESCALE_N_O,
    input wire logic [3:0] PRESCALE_M_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    logic [7:0] feat, low, high;
    logic auto_on;
    assign auto_on = feat[UEFR_FEAT_ENHANCED] & feat[UEFR_FEAT_AUTO_RTS];
    // shadows follow software writes only
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            feat <= 8'h00;
            low <= 8'h00;
            high <= 8'h00;
        end else if (WR_I) begin
            case (ADDR_I)
                UEFR_OFF_FEATURE: feat <= WDATA_I;
                UEFR_OFF_FLOW_LOW: low <= WDATA_I;
                UEFR_OFF_FLOW_HIGH: high <= WDATA_I;
                default: ;
            endcase
        end
    end
    // ********************************
    // assertions
    // ********************************
    a_status_rsvd: assert property (
        $past(RD_I) && $past(ADDR_I) == UEFR_OFF_ADV_STATUS |-> RDATA_O[7:4] == 4'h0)
        else $error("status reserved bits set");
    a_status_levels: assert property (
        $past(RD_I) && $past(ADDR_I) == UEFR_OFF_ADV_STATUS
        && $past({REMOTE_DIS_I, REMOTE_TERM_I}, 2) == $past({REMOTE_DIS_I, REMOTE_TERM_I})
        |-> RDATA_O[1:0] == $past({REMOTE_DIS_I, REMOTE_TERM_I}))
        else $error("status level bits wrong");
    a_irq_gate: assert property (!$past(PAUSE_IRQ_EN_I) |-> !FLOW_IRQ_O)
        else $error("flow interrupt while disabled");
    a_rts_halt: assert property (auto_on && 8'(RX_COUNT_I) >= high |=> RTS_N_O)
        else $error("rts not inactive at high level");
    a_rts_release: assert property (
        auto_on && 8'(RX_COUNT_I) < low && 8'(RX_COUNT_I) < high |=> !RTS_N_O)
        else $error("rts not released below low level");
    a_rts_manual: assert property (!auto_on |=> !RTS_N_O)
        else $error("rts inactive without auto mode");
    a_tx_level: assert property (
        WR_I && ADDR_I == UEFR_OFF_TX_IRQ_LEVEL |-> ##2 TX_IRQ_LEVEL_O == $past(WDATA_I, 2))
        else $error("tx trigger level output wrong");
    a_prescale_out: assert property (
        WR_I && ADDR_I == UEFR_OFF_PRESCALE
        |-> ##2 {PRESCALE_M_O, PRESCALE_N_O} == $past(WDATA_I, 2))
        else $error("prescale fields wrong");
endmodule
bind uefr_regs uefr_regs_sva #(.COUNT_W(COUNT_W)) u_uefr_regs_sva (
    .CLK_SYS_I, .RST_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .RX_COUNT_I,
    .REMOTE_TERM_I, .REMOTE_DIS_I, .PAUSE_IRQ_EN_I, .RTS_N_O, .FLOW_IRQ_O,
    .TX_IRQ_LEVEL_O, .PRESCALE_N_O, .PRESCALE_M_O
);
`default_nettype wire

/* dv/uefr_remote_station.sv */
/* Remote serial station: sends characters into the receive path and sets
   the receive fifo fill. Assumes the register group's clock and rts. */
`timescale 1ns/1ps
`default_nettype none
module uefr_remote_station (
    input wire logic clk_i,
    input wire logic rts_n_i,
    output logic [7:0] char_o,
    output logic valid_o,
    output logic [7:0] fill_o
);
    int gap = 0;
    initial begin
        char_o = 8'h00;
        valid_o = 1'b0;
        fill_o = 8'h00;
    end
    // a halted station holds off, but never forever
    task automatic send(input logic [7:0] c);
        for (int n = 0; n < 200 && rts_n_i; n++) begin
            @(posedge clk_i);
        end
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        char_o <= c;
        valid_o <= 1'b1;
        fill_o <= fill_o + 8'h01;
        @(posedge clk_i);
        valid_o <= 1'b0;
        char_o <= ~c; // stale character must not look valid
    endtask
    task automatic set_fill(input logic [7:0] f);
        @(posedge clk_i);
        fill_o <= f;
    endtask
endmodule
`default_nettype wire

/* dv/uart_enhanced_flow_regs_test.sv */
/* Testbench for the enhanced flow register group.
   Assumes the remote station model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module uart_enhanced_flow_regs_test;
    import uefr_pkg::*;
    typedef struct {string nm; logic [7:0] v;} uefr_note_type;
    localparam logic [7:0] ST [3] = '{8'h01, 8'h02, 8'h00};
    // in-band rows: feature, character, status, halt
    localparam logic [7:0] DF [8] = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h02, 8'h32, 8'h03, 8'h00};
    localparam logic [7:0] DC [8] = '{8'h34, 8'h32, 8'h33, 8'h33, 8'h31, 8'h34, 8'h34, 8'h33};
    localparam logic [7:0] DS [8] = '{8'h04, 8'h04, 8'h00, 8'h04, 8'h04, 8'h08, 8'h04, 8'h00};
    localparam logic DH [8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    // auto rts rows: feature, fill, rts_n
    localparam logic [7:0] RF [7] = '{8'h50, 8'h50, 8'h50, 8'h50, 8'h50, 8'h50, 8'h10};
    localparam logic [7:0] RC [7] = '{8'h03, 8'h07, 8'h08, 8'h04, 8'h03, 8'h08, 8'h08};
    localparam logic RR [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0, rd = 1'b0, term = 1'b0, dis = 1'b0, irq_en = 1'b0, rd_q = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, sclk = 8'h00, ls_cnt = 8'h00, tx_cnt = 8'h00;
    logic [7:0] rdata, rx_char, rx_fill, lvl_tx, lvl_rx, c_rx, c_ls, c_tx;
    logic [3:0] pre_n, pre_m;
    logic rx_valid, tx_halt, rts_n, irq;
    logic [7:0] v [8'h0b:8'h14];
    uefr_note_type notes[$];
    uefr_note_type cur;
    int n_mismatch = 0;
    int checked = 0;
    always #2 clk = ~clk;
    uefr_regs #(.COUNT_W(8)) DUT (
        .CLK_SYS_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .RX_COUNT_I(rx_fill), .LINE_STAT_COUNT_I(ls_cnt),
        .TX_COUNT_I(tx_cnt), .SAMPLE_CLK_I(sclk), .RX_CHAR_I(rx_char),
        .RX_CHAR_VALID_I(rx_valid), .REMOTE_TERM_I(term), .REMOTE_DIS_I(dis),
        .PAUSE_IRQ_EN_I(irq_en), .TX_HALT_O(tx_halt), .RTS_N_O(rts_n), .FLOW_IRQ_O(irq),
        .TX_IRQ_LEVEL_O(lvl_tx), .RX_IRQ_LEVEL_O(lvl_rx), .PRESCALE_N_O(pre_n),
        .PRESCALE_M_O(pre_m)
    );
    uefr_remote_station st (
        .clk_i(clk), .rts_n_i(rts_n), .char_o(rx_char), .valid_o(rx_valid), .fill_o(rx_fill)
    );
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic read_reg(input logic [7:0] a, input logic [7:0] e);
        notes.push_back('{$sformatf("reg %h", a), e});
        bus(1'b0, 1'b1, a, 8'h00);
    endtask
    // the extra ns lets registered outputs settle before a check
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
        #1;
    endtask
    always @(posedge clk) begin
        if (rd_q) begin
            cur = notes.pop_front();
            `CHK(cur.nm, cur.v, rdata)
        end
        rd_q <= rd;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        void'($urandom(31406));
        sclk <= 8'($urandom);
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 8'h0b; a <= 8'h14; a++) begin
            read_reg(8'(a), 8'h00);
        end
        read_reg(8'h15, 8'h00);
        read_reg(8'h16, sclk);
        read_reg(8'h20, 8'h00);
        for (int a = 8'h0b; a <= 8'h14; a++) begin
            v[a] = (a == 8'h14) ? {4'($urandom % 3), 4'($urandom)} : 8'($urandom);
            write_reg(8'(a), (a == 8'h0f) ? 8'hff : v[a]);
        end
        v[8'h0f] = 8'h00;
        write_reg(8'h15, 8'hff);
        write_reg(8'h16, 8'hff);
        for (int a = 8'h0b; a <= 8'h14; a++) begin
            read_reg(8'(a), v[a]);
        end
        idle(3);
        `CHK("tx level", v[8'h10], lvl_tx)
        `CHK("rx level", v[8'h11], lvl_rx)
        `CHK("prescale", v[8'h14], {pre_m, pre_n})
        c_rx = 8'($urandom);
        c_ls = 8'($urandom);
        c_tx = 8'($urandom);
        ls_cnt <= c_ls;
        tx_cnt <= c_tx;
        st.set_fill(c_rx);
        write_reg(8'h07, 8'h40);
        read_reg(8'h15, c_rx);
        write_reg(8'h07, 8'h80);
        read_reg(8'h15, c_ls);
        read_reg(8'h16, c_tx);
        write_reg(8'h07, 8'h00);
        read_reg(8'h16, sclk);
        foreach (ST[i]) begin
            term <= ST[i][0];
            dis <= ST[i][1];
            idle(3);
            read_reg(8'h0f, ST[i]);
        end
        for (int a = 0; a < 4; a++) begin
            write_reg(8'(8'h0b + a), 8'(8'h31 + a));
        end
        irq_en <= 1'b1;
        foreach (DF[i]) begin
            st.gap = i % 3;
            write_reg(8'h08, DF[i]);
            idle(1);
            st.send(DC[i]);
            idle(2);
            `CHK("halt", DH[i], tx_halt)
            `CHK("flow irq", DS[i] != 8'h00, irq)
            read_reg(8'h0f, DS[i]);
            read_reg(8'h0f, 8'h00);
            idle(3);
            `CHK("flow irq", 1'b0, irq)
        end
        write_reg(8'h12, 8'h04);
        write_reg(8'h13, 8'h08);
        foreach (RF[i]) begin
            write_reg(8'h08, RF[i]);
            idle(1);
            st.set_fill(RC[i]);
            idle(3);
            `CHK("rts", RR[i], rts_n)
        end
        idle(2);
        wrap_up();
    end
endmodule
`default_nettype wire
